// File: design/serrst_status.sv
`timescale 1ns/10ps
`include "serrst_cfg.svh"
// What this block does
// - Address parity error sets flag bit 0
// - Posted write data parity sets bit 1
// - Posted write undelivered after limit sets bit 2
// - Posted write target abort sets bit 3
// - Posted write master abort sets bit 4
// - Delayed write undelivered after limit sets bit 5
// - Fruitless delayed read at limit sets bit 6
// - Delayed transaction master timeout sets bit 7
// - Byte 6Ah, resets zero, write one clears
module serrst_status
  import serrst_pkg::*;
#(
  // Attempts before a transaction is given up
  parameter int ATTEMPT_LIMIT = `SERRST_ATTEMPT_LIMIT
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Configuration access from the primary bus
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_n_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // Error events from the forwarding logic
  input wire logic addr_perr_i,
  input wire logic pw_perr_i,
  input wire logic pw_attempt_fail_i,
  input wire logic pw_delivered_i,
  input wire logic pw_tabort_i,
  input wire logic pw_mabort_i,
  input wire logic dw_attempt_fail_i,
  input wire logic dw_delivered_i,
  input wire logic dr_attempt_nodata_i,
  input wire logic dr_data_i,
  input wire logic mtimeout_i,
  // System error request and cause view
  output logic serr_pulse_o,
  output logic [7:0] reason_o
);

  // ==========================================================
  // Attempt counters
  // Last count before the limit is reached
  localparam serrst_count_t LIM_M1 = serrst_count_t'(ATTEMPT_LIMIT - 1);

  // Failed attempt and success strobes per channel
  logic [2:0] fail_w;
  // Transaction delivered or data obtained, counter restarts
  logic [2:0] done_w;
  // Limit reached on this failed attempt
  logic [2:0] hit_w;
  // Counter state per channel
  serrst_count_t cnt_reg [3];

  assign fail_w = {dr_attempt_nodata_i, dw_attempt_fail_i, pw_attempt_fail_i};
  assign done_w = {dr_data_i, dw_delivered_i, pw_delivered_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_chan
      // Limit compare is on the count of earlier failures
      assign hit_w[gi] = fail_w[gi] && (cnt_reg[gi] == LIM_M1);
      // Next count: restart on success or on giving up
      serrst_count_t cnt_next;
      assign cnt_next = (done_w[gi] || hit_w[gi]) ? '0 :
                        fail_w[gi] ? serrst_count_t'(cnt_reg[gi] + 25'h0000001) :
                        cnt_reg[gi];
      // Counter runs every cycle; held value when idle
      always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
          cnt_reg[gi] <= '0;
        end else begin
          cnt_reg[gi] <= cnt_next;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Register access decode
  // Cause register lane addressed by a configuration access
  logic lane_sel_w;
  logic wr_hit_w;
  logic rd_hit_w;
  assign lane_sel_w = (cfg_addr_i == `SERRST_DWORD_ADDR) && !cfg_be_n_i[`SERRST_LANE];
  assign wr_hit_w = cfg_wr_i && lane_sel_w;
  assign rd_hit_w = cfg_rd_i && lane_sel_w;

  // ==========================================================
  // Cause flags
  serrst_flags_t flags_reg;
  serrst_flags_t flags_next;
  serrst_flags_t set_w;
  serrst_flags_t clr_w;

  // One set strobe per cause, in flag bit order
  assign set_w = {
    mtimeout_i,
    hit_w[2],
    hit_w[1],
    pw_mabort_i,
    pw_tabort_i,
    hit_w[0],
    pw_perr_i,
    addr_perr_i
  };
  // Only ones in the written lane clear; zeros do nothing
  assign clr_w = wr_hit_w ? cfg_wdata_i[`SERRST_LANE_HI:`SERRST_LANE_LO] : 8'h00;
  // A cause in the clearing cycle still lands, set wins
  assign flags_next = (flags_reg & ~clr_w) | set_w;

  // Sticky flags, cleared only by software or reset
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      flags_reg <= `SERRST_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ==========================================================
  // System error request
  // One pulse for every cycle with a new cause present
  logic serr_next;
  assign serr_next = |set_w;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      serr_pulse_o <= 1'b0;
    end else begin
      serr_pulse_o <= serr_next;
    end
  end

  // Cause view follows the flag register directly
  assign reason_o = flags_reg;

  // ==========================================================
  // Read return
  // Other lanes of the dword belong to other registers and read zero here
  logic [31:0] rdata_next;
  assign rdata_next = rd_hit_w ? {8'h00, flags_reg, 16'h0000} : 32'h0000_0000;

  // Every read is answered one cycle later, mapped or not
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cfg_rdata_o <= 32'h0000_0000;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rdata_o <= rdata_next;
      cfg_rvalid_o <= cfg_rd_i;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  // Cause events
  sequence s_pw_give_up;
    pw_attempt_fail_i && (cnt_reg[0] == LIM_M1);
  endsequence
  sequence s_dw_give_up;
    dw_attempt_fail_i && (cnt_reg[1] == LIM_M1);
  endsequence
  sequence s_dr_give_up;
    dr_attempt_nodata_i && (cnt_reg[2] == LIM_M1);
  endsequence
  // Flag raised together with the error request
  sequence s_flag_and_serr(int b);
    reason_o[b] && serr_pulse_o;
  endsequence

  a_addr_perr_flag: assert property (addr_perr_i |=> s_flag_and_serr(0))
    else $error("address parity cause not recorded");
  a_pw_perr_flag: assert property (pw_perr_i |=> s_flag_and_serr(1))
    else $error("posted write parity cause not recorded");
  a_pw_limit_flag: assert property (s_pw_give_up |=> s_flag_and_serr(2)
      ##0 cnt_reg[0] == '0)
    else $error("posted write nondelivery not recorded");
  a_pw_early_quiet: assert property (pw_attempt_fail_i && !pw_perr_i && !addr_perr_i
      && !pw_tabort_i && !pw_mabort_i && !dw_attempt_fail_i && !dr_attempt_nodata_i
      && !mtimeout_i && cnt_reg[0] != LIM_M1 |=> !serr_pulse_o)
    else $error("error request before attempt limit");
  a_pw_tabort_flag: assert property (pw_tabort_i |=> s_flag_and_serr(3))
    else $error("target abort cause not recorded");
  a_pw_mabort_flag: assert property (pw_mabort_i |=> s_flag_and_serr(4))
    else $error("master abort cause not recorded");
  a_dw_limit_flag: assert property (s_dw_give_up |=> s_flag_and_serr(5))
    else $error("delayed write nondelivery not recorded");
  a_dr_limit_flag: assert property (s_dr_give_up |=> s_flag_and_serr(6))
    else $error("delayed read no data not recorded");
  a_mtimeout_flag: assert property (mtimeout_i |=> s_flag_and_serr(7))
    else $error("master timeout cause not recorded");

  // Register behaviour
  a_reset_zero: assert property (disable iff (1'b0) reset_i |=> reason_o == 8'h00)
    else $error("cause flags not zero after reset");
  a_w1c_clear: assert property (wr_hit_w && cfg_wdata_i[16] && !addr_perr_i
      |=> !reason_o[0])
    else $error("write one did not clear flag");
  a_read_value: assert property (rd_hit_w |=> cfg_rvalid_o
      && cfg_rdata_o[23:16] == $past(reason_o))
    else $error("read does not return cause flags");
  // Reset is synchronous: the edge that samples it high must not start a check
  a_flags_sticky: assert property (!reset_i |=> ((reason_o & $past(reason_o & ~clr_w))
      == $past(reason_o & ~clr_w)))
    else $error("flag lost without a clearing write");

  // Counter and request housekeeping
  a_done_restart: assert property (pw_delivered_i |=> cnt_reg[0] == '0)
    else $error("delivery did not restart attempt count");
  // A newly raised flag always comes with its error request
  a_new_flag_serr: assert property ((reason_o & ~$past(reason_o)) == 8'h00
      || serr_pulse_o)
    else $error("flag raised without an error request");

endmodule : serrst_status

// File: design/serrst_cfg.svh
`ifndef SERRST_CFG_SVH
`define SERRST_CFG_SVH

// ==========================================================
// Register placement in configuration space
// Dword that holds the cause register
`define SERRST_DWORD_ADDR 8'h68
// Byte address of the cause register itself
`define SERRST_BYTE_ADDR 8'h6a
// Byte lane of the cause register inside its dword
`define SERRST_LANE 2
// Low and high data bit of that lane
`define SERRST_LANE_LO 16
`define SERRST_LANE_HI 23
// Reset value of the cause flags
`define SERRST_RESET 8'h00

// ==========================================================
// Flag positions
`define SERRST_B_ADDR_PERR 0
`define SERRST_B_PW_PERR 1
`define SERRST_B_PW_NODELIV 2
`define SERRST_B_PW_TABORT 3
`define SERRST_B_PW_MABORT 4
`define SERRST_B_DW_NODELIV 5
`define SERRST_B_DR_NODATA 6
`define SERRST_B_MTIMEOUT 7

// ==========================================================
// Retry limit, two to the twenty-fourth attempts
`define SERRST_ATTEMPT_LIMIT 32'h0100_0000

`endif

// File: design/serrst_pkg.sv
// ==========================================================
// Types shared by the cause register logic
package serrst_pkg;
  // One bit per recorded cause
  typedef logic [7:0] serrst_flags_t;
  // Attempt counter, wide enough for the retry limit
  typedef logic [24:0] serrst_count_t;
  // One-hot code of the three attempt-counting channels
  typedef enum logic [2:0] {
    SERRST_CH_PW = 3'h1,
    SERRST_CH_DW = 3'h2,
    SERRST_CH_DR = 3'h4
  } serrst_chan_t;
endpackage : serrst_pkg

// File: testbench/serrst_host.sv
`timescale 1ns/10ps
// ==========================================================
// Configuration master on the primary bus, one access at a time
module serrst_host (
  // Clock
  input wire logic clk_i,
  // Access request toward the cause register
  output logic [7:0] addr_o,
  output logic [3:0] be_n_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  // Read answer
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i
);
  // Idle bus at time zero, all lanes disabled
  initial begin
    addr_o = 8'h00;
    be_n_o = 4'hf;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // One-cycle strobe; q returns {rvalid, rdata} from the cycle after it
  task automatic acc(input logic is_rd, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d, output logic [32:0] q);
    @(posedge clk_i);
    addr_o <= a;
    be_n_o <= be;
    wdata_o <= d;
    rd_o <= is_rd;
    wr_o <= ~is_rd;
    @(posedge clk_i);
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    // Released lines flip so a stale value is never mistaken for a held one
    addr_o <= ~a;
    be_n_o <= ~be;
    wdata_o <= ~d;
    #1;
    q = {rvalid_i, rdata_i};
  endtask : acc
endmodule : serrst_host

// File: testbench/testbench.sv
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the cause register
module testbench;
  localparam int LIM = 4; // Short retry limit keeps the run brief
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [10:0] ev = '0; // Cause, attempt and success pulses
  logic [7:0] addr;
  logic [3:0] be_n;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wr;
  logic rd;
  logic rvalid;
  logic serr;
  logic [7:0] reason;
  logic [32:0] r; // Last read answer
  int mismatches = 0;
  int checks = 0;
  logic [7:0] want; // Flags a scenario should leave behind
  // Failed-attempt line and give-up flag per counting channel; success line is one above
  int fail_idx [3] = '{2, 6, 8};
  logic [7:0] gave_up [3] = '{8'h04, 8'h20, 8'h40};
  // Rows: pulse index, pulse count, expected flags
  logic [15:0] rows [8] = '{16'h0101, 16'h1102, 16'h2404, 16'h4108,
                            16'h5110, 16'h6420, 16'h8440, 16'ha180};

  always #5 sys_clk_i = ~sys_clk_i;

  serrst_status #(.ATTEMPT_LIMIT(LIM)) uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .cfg_addr_i(addr), .cfg_be_n_i(be_n), .cfg_wdata_i(wdata), .cfg_wr_i(wr), .cfg_rd_i(rd),
    .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .addr_perr_i(ev[0]), .pw_perr_i(ev[1]),
    .pw_attempt_fail_i(ev[2]), .pw_delivered_i(ev[3]), .pw_tabort_i(ev[4]),
    .pw_mabort_i(ev[5]), .dw_attempt_fail_i(ev[6]), .dw_delivered_i(ev[7]),
    .dr_attempt_nodata_i(ev[8]), .dr_data_i(ev[9]), .mtimeout_i(ev[10]),
    .serr_pulse_o(serr), .reason_o(reason));

  serrst_host host (.clk_i(sys_clk_i), .addr_o(addr), .be_n_o(be_n), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .rdata_i(rdata), .rvalid_i(rvalid));

  // ==========================================================
  // Shared helpers
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Pulses one event line n times back to back, then lets the flag land
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge sys_clk_i) ev <= 11'h1 << idx;
    end
    @(posedge sys_clk_i) ev <= '0;
    #1;
  endtask : pulse

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    host.acc(1'b1, 8'h68, 4'hb, '0, r);
    check(r, {1'b1, 32'h0});
    // Every cause sets its own flag, reads back in lane 2, clears by writing one
    foreach (rows[i]) begin
      want = rows[i][7:0];
      pulse(rows[i][15:12], rows[i][11:8]);
      check({serr, reason}, {1'b1, want});
      host.acc(1'b1, 8'h68, 4'hb, '0, r);
      check(r, {1'b1, 8'h0, want, 16'h0});
      host.acc(1'b0, 8'h68, 4'hb, {8'h0, want, 16'h0}, r);
      check(r[32], 1'b0);
      check(reason, 8'h00);
    end
    // Zero mask, disabled lane and unmapped writes leave a set flag alone
    pulse(0, 1);
    host.acc(1'b0, 8'h68, 4'hb, 32'h0, r);
    host.acc(1'b0, 8'h68, 4'he, 32'hffff_ffff, r);
    host.acc(1'b0, 8'h6c, 4'h0, 32'hffff_ffff, r);
    // A later cause adds its flag beside the kept one
    pulse(1, 1);
    check(reason, 8'h03);
    host.acc(1'b1, 8'h6c, 4'h0, '0, r);
    check(r, {1'b1, 32'h0});
    // Cause and clear in the same cycle: the set must win
    fork
      host.acc(1'b0, 8'h68, 4'hb, 32'h00ff_0000, r);
      begin
        @(posedge sys_clk_i) ev <= 11'h001;
        @(posedge sys_clk_i) ev <= '0;
      end
    join
    check(reason, 8'h01);
    // A success restarts the attempt count of every channel
    want = 8'h01;
    foreach (fail_idx[c]) begin
      pulse(fail_idx[c], LIM - 1);
      pulse(fail_idx[c] + 1, 1);
      pulse(fail_idx[c], LIM - 1);
      check(reason, want);
      pulse(fail_idx[c], 1);
      want = want | gave_up[c];
      check({serr, reason}, {1'b1, want});
    end
    // Reset in mid-run clears every flag
    @(posedge sys_clk_i) reset_i <= 1'b1;
    @(posedge sys_clk_i) reset_i <= 1'b0;
    #1;
    check({serr, reason}, 9'h000);
    host.acc(1'b1, 8'h68, 4'hb, '0, r);
    check(r, {1'b1, 32'h0});
    wrap_up();
  end
endmodule : testbench
